// ==== hw/wia_averager.sv ====
module wia_averager
  import wia_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic setup_valid,
  input wire wia_pkg::wia_setup_s setup,
  input wire logic sample_valid,
  input wire wia_pkg::wia_sample_s sample,
  output logic sample_ready,
  output logic result_valid,
  output wia_pkg::wia_result_s result
);
  import wia_pkg::*;

  // ************************************************************
  // helpers
  // ************************************************************
  // history address of a slot within a channel
  function automatic logic [WIA_ADDR_W-1:0] slot_addr(
    input logic [WIA_CH_W-1:0] ch,
    input logic [WIA_COUNT_W-1:0] slot);
    slot_addr = {ch, slot};
  endfunction

  // clamp a setting to its least legal value
  function automatic logic [WIA_COUNT_W-1:0] fix_count(
    input logic [WIA_COUNT_W-1:0] v);
    fix_count = (v < WIA_COUNT_MIN) ? WIA_COUNT_MIN : v;
  endfunction

  logic [WIA_COUNT_W-1:0] count_cfg [WIA_CHANNELS];
  logic [WIA_WIN_W-1:0] win_cfg [WIA_CHANNELS];
  logic signed [WIA_SUM_W-1:0] sum [WIA_CHANNELS];
  logic [WIA_COUNT_W-1:0] fill [WIA_CHANNELS];
  logic [WIA_COUNT_W-1:0] head [WIA_CHANNELS];
  logic signed [WIA_DATA_W-1:0] centre [WIA_CHANNELS];
  logic [WIA_CHANNELS-1:0] live;
  wia_state_e state;
  wia_sample_s cur;
  logic signed [WIA_DATA_W-1:0] old_val;
  logic signed [WIA_DATA_W:0] dev;
  logic [WIA_DATA_W:0] dev_abs;
  logic outside;
  logic full;
  logic signed [WIA_SUM_W-1:0] next_sum;
  logic ram_wr;
  logic [WIA_COUNT_W-1:0] wr_slot;

  // ************************************************************
  // per-channel settings
  // ************************************************************
  // each channel keeps its own length and window
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      for (int i = 0; i < WIA_CHANNELS; i++)
      begin
        count_cfg[i] <= WIA_COUNT_RESET;
        win_cfg[i] <= WIA_WIN_RESET;
      end
    end
    else if (setup_valid)
    begin
      count_cfg[setup.channel] <= fix_count(setup.sample_count_setting);
      win_cfg[setup.channel] <= (setup.window_size_setting < WIA_WIN_MIN)
        ? WIA_WIN_MIN : setup.window_size_setting;
    end
  end

  // ************************************************************
  // deviation and window test
  // ************************************************************
  // values are already in display counts
  always_comb
  begin
    dev = {cur.value[WIA_DATA_W-1], cur.value}
      - {centre[cur.channel][WIA_DATA_W-1], centre[cur.channel]};
    dev_abs = dev[WIA_DATA_W] ? -dev : dev;
    outside = !live[cur.channel]
      || (dev_abs > {9'h000, win_cfg[cur.channel]});
    // a restarted history always begins at slot zero
    wr_slot = outside ? '0 : head[cur.channel];
    full = fill[cur.channel] >= count_cfg[cur.channel];
    ram_wr = (state == WIA_CALC);
    if (outside)
    begin
      next_sum = WIA_SUM_W'(cur.value);
    end
    else if (full)
    begin
      next_sum = sum[cur.channel] + WIA_SUM_W'(cur.value)
        - WIA_SUM_W'(old_val);
    end
    else
    begin
      next_sum = sum[cur.channel] + WIA_SUM_W'(cur.value);
    end
  end

  // ************************************************************
  // history of samples
  // ************************************************************
  wia_history_ram u_hist (
    .clk_sys(clk_sys),
    .wr_en(ram_wr),
    .wr_addr(slot_addr(cur.channel, wr_slot)),
    .wr_data(cur.value),
    .rd_addr(slot_addr(cur.channel, head[cur.channel])),
    .rd_data(old_val)
  );

  // ************************************************************
  // sequencer
  // ************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      state <= WIA_IDLE;
      cur <= '0;
      sample_ready <= 1'b1;
    end
    else
    begin
      case (state)
        WIA_IDLE:
        begin
          if (sample_valid)
          begin
            cur <= sample;
            sample_ready <= 1'b0;
            state <= WIA_READ;
          end
        end
        WIA_READ: state <= WIA_CALC;
        WIA_CALC: state <= WIA_EMIT;
        WIA_EMIT:
        begin
          sample_ready <= 1'b1;
          state <= WIA_IDLE;
        end
        default: state <= WIA_IDLE;
      endcase
    end
  end

  // ************************************************************
  // running state per channel
  // ************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      live <= '0;
      for (int i = 0; i < WIA_CHANNELS; i++)
      begin
        sum[i] <= '0;
        fill[i] <= '0;
        head[i] <= '0;
        centre[i] <= '0;
      end
    end
    else if (state == WIA_CALC)
    begin
      sum[cur.channel] <= next_sum;
      if (outside)
      begin
        centre[cur.channel] <= cur.value;
        live[cur.channel] <= 1'b1;
        fill[cur.channel] <= WIA_COUNT_MIN;
        head[cur.channel] <= (count_cfg[cur.channel] == WIA_COUNT_MIN)
          ? '0 : WIA_COUNT_MIN;
      end
      else
      begin
        if (!full)
        begin
          fill[cur.channel] <= fill[cur.channel] + WIA_COUNT_MIN;
        end
        head[cur.channel] <= (head[cur.channel] + WIA_COUNT_MIN
          >= count_cfg[cur.channel]) ? '0
          : head[cur.channel] + WIA_COUNT_MIN;
      end
    end
  end

  // ************************************************************
  // output
  // ************************************************************
  logic signed [WIA_SUM_W-1:0] avg_sum;
  logic [WIA_COUNT_W-1:0] avg_n;
  logic avg_raw;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      avg_sum <= '0;
      avg_n <= WIA_COUNT_MIN;
      avg_raw <= 1'b1;
    end
    else if (state == WIA_CALC)
    begin
      avg_sum <= next_sum;
      avg_n <= outside ? WIA_COUNT_MIN
        : (full ? count_cfg[cur.channel] : fill[cur.channel] + WIA_COUNT_MIN);
      avg_raw <= outside;
    end
  end

  // divide in the emit cycle and register the result
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      result_valid <= 1'b0;
      result <= '0;
    end
    else
    begin
      result_valid <= (state == WIA_EMIT);
      if (state == WIA_EMIT)
      begin
        result.channel <= cur.channel;
        result.averaged <= !avg_raw;
        result.value <= avg_raw ? cur.value
          : WIA_DATA_W'(avg_sum / $signed({1'b0, avg_n}));
      end
    end
  end

endmodule

// ==== hw/wia_history_ram.sv ====
module wia_history_ram
  import wia_pkg::*;
(
  input wire logic clk_sys,
  input wire logic wr_en,
  input wire logic [wia_pkg::WIA_ADDR_W-1:0] wr_addr,
  input wire logic signed [wia_pkg::WIA_DATA_W-1:0] wr_data,
  input wire logic [wia_pkg::WIA_ADDR_W-1:0] rd_addr,
  output logic signed [wia_pkg::WIA_DATA_W-1:0] rd_data
);
  import wia_pkg::*;

  logic signed [WIA_DATA_W-1:0] mem [WIA_CHANNELS*WIA_DEPTH];

  // ************************************************************
  // registered read, plain write
  // ************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

// ==== pkg/wia_pkg.sv ====
// Contract
// - averaging length settable from 1 to 255
// - window size settable from 1 to 65535
// - in-window samples give running average output
// - out-of-window sample output raw at once
// - after excursion, new window and restart averaging
// - independent settings per channel, selected by channel
// - deviation compared in display count units
package wia_pkg;

  // ************************************************************
  // sizes
  // ************************************************************
  localparam int unsigned WIA_CHANNELS = 4;
  localparam int unsigned WIA_CH_W = 2;
  localparam int unsigned WIA_DATA_W = 24;
  localparam int unsigned WIA_COUNT_W = 8;
  localparam int unsigned WIA_WIN_W = 16;
  localparam int unsigned WIA_SUM_W = 32;
  localparam int unsigned WIA_DEPTH = 256;
  localparam int unsigned WIA_ADDR_W = 10;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] WIA_COUNT_RESET = 8'h01;
  localparam logic [15:0] WIA_WIN_RESET = 16'hffff;
  localparam logic [7:0] WIA_COUNT_MIN = 8'h01;
  localparam logic [15:0] WIA_WIN_MIN = 16'h0001;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic [1:0] channel;
    logic signed [23:0] value;
  } wia_sample_s;

  typedef struct packed {
    logic [1:0] channel;
    logic [7:0] sample_count_setting;
    logic [15:0] window_size_setting;
  } wia_setup_s;

  typedef struct packed {
    logic [1:0] channel;
    logic signed [23:0] value;
    logic averaged;
  } wia_result_s;

  typedef enum logic [3:0] {
    WIA_IDLE = 4'b0001,
    WIA_READ = 4'b0010,
    WIA_CALC = 4'b0100,
    WIA_EMIT = 4'b1000
  } wia_state_e;

endpackage

// ==== verification/wia_averager_asserts.sv ====
module wia_averager_chk
  import wia_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic sample_valid,
  input wire wia_pkg::wia_sample_s sample,
  input wire logic sample_ready,
  input wire logic result_valid,
  input wire wia_pkg::wia_result_s result
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] seen;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  // ************************************************************
  // handshake timing and result contents
  // ************************************************************
  sequence s_take;
    sample_valid && sample_ready;
  endsequence
  sequence s_answer;
    ##1 !result_valid [*3] ##1 result_valid;
  endsequence
  // channels that have produced a result since reset
  always_ff @(posedge clk_sys)
    if (srst)
      seen <= '0;
    else if (result_valid)
      seen[result.channel] <= 1'b1;
  a_answer_four: assert property (s_take |-> s_answer)
    else $error("result not four cycles after take");
  a_busy_three: assert property (
    s_take |=> !sample_ready [*3] ##1 sample_ready)
    else $error("ready not low for three cycles");
  a_pulse_one: assert property (result_valid |=> !result_valid)
    else $error("result valid longer than one cycle");
  a_result_hold: assert property ($changed(result) |-> result_valid)
    else $error("result changed without valid");
  a_chan_match: assert property (
    result_valid |-> result.channel == $past(sample.channel, 4))
    else $error("result channel differs from sample");
  a_raw_value: assert property (
    result_valid && !result.averaged
    |-> result.value == $past(sample.value, 4))
    else $error("raw result differs from sample");
  a_take_cause: assert property (
    result_valid |-> $past(sample_valid && sample_ready, 4))
    else $error("result without a taken sample");
  a_first_raw: assert property (
    result_valid && !seen[result.channel] |-> !result.averaged)
    else $error("first result after reset averaged");
endmodule

bind wia_averager wia_averager_chk u_chk (.clk_sys(clk_sys), .srst(srst),
  .sample_valid(sample_valid), .sample(sample), .sample_ready(sample_ready),
  .result_valid(result_valid), .result(result));

// ==== verification/wia_sample_source.sv ====
module wia_sample_source
  import wia_pkg::*;
(
  input wire logic clk_sys,
  input wire logic go,
  input wire wia_pkg::wia_sample_s next_sample,
  input wire logic sample_ready,
  output logic sample_valid,
  output wia_pkg::wia_sample_s sample
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // sample offer
  // ************************************************************
  initial
  begin
    sample_valid = 1'b0;
    sample = '0;
  end
  // hold until taken, then scramble so a stale value is never reused
  always @(posedge clk_sys)
    if (sample_valid && sample_ready)
    begin
      sample_valid <= 1'b0;
      sample <= ~sample;
    end
    else if (go)
    begin
      sample_valid <= 1'b1;
      sample <= next_sample;
    end
endmodule

// ==== verification/windowed_input_averager_bench.sv ====
module windowed_input_averager_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import wia_pkg::*;
  logic clk_sys, srst, setup_valid, go;
  logic sample_valid, sample_ready, result_valid;
  wia_setup_s setup;
  wia_sample_s next_sample, sample;
  wia_result_s result;
  int failures, samples_checked;
  int cen[4], n[4], w[4], base[4];
  int sp[4] = '{2, 60000, 2, 1200};
  bit est[4];
  int hist[4][$];
  // ************************************************************
  // clock, design and source
  // ************************************************************
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  wia_averager u_dut (.clk_sys(clk_sys), .srst(srst),
    .setup_valid(setup_valid), .setup(setup), .sample_valid(sample_valid),
    .sample(sample), .sample_ready(sample_ready),
    .result_valid(result_valid), .result(result));
  wia_sample_source u_src (.clk_sys(clk_sys), .go(go),
    .next_sample(next_sample), .sample_ready(sample_ready),
    .sample_valid(sample_valid), .sample(sample));
  // reference: raw on excursion, else mean of last n held samples
  function automatic logic [26:0] model(int ch, int x);
    int s, d;
    d = x - cen[ch];
    if (d < 0) d = -d;
    if (!est[ch] || d > w[ch])
    begin
      est[ch] = 1;
      cen[ch] = x;
      hist[ch].delete();
      hist[ch].push_back(x);
      return {ch[1:0], x[23:0], 1'b0};
    end
    hist[ch].push_back(x);
    while (hist[ch].size() > n[ch]) void'(hist[ch].pop_front());
    s = 0;
    foreach (hist[ch][i]) s += hist[ch][i];
    s = s / int'(hist[ch].size());
    return {ch[1:0], s[23:0], 1'b1};
  endfunction
  task automatic test_done;
    if (failures == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(logic [28:0] s, logic [28:0] e);
    samples_checked++;
    if (s !== e)
    begin
      failures++;
      $display("ERROR %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic rst_seq;
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    foreach (est[i])
    begin
      est[i] = 0;
      n[i] = 1;
      w[i] = 65535;
      hist[i].delete();
    end
    @(negedge clk_sys);
    chk({sample_ready, result_valid, result}, {2'b10, 27'h0});
    @(posedge clk_sys);
  endtask
  task automatic cfg(int ch, int c, int win);
    setup_valid <= 1'b1;
    setup <= {ch[1:0], c[7:0], win[15:0]};
    n[ch] = (c == 0) ? 1 : c;
    w[ch] = (win == 0) ? 1 : win;
    @(posedge clk_sys);
    setup_valid <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic send(int ch, int x);
    logic [26:0] e;
    e = model(ch, x);
    go <= 1'b1;
    next_sample <= {ch[1:0], x[23:0]};
    @(posedge clk_sys);
    go <= 1'b0;
    for (int i = 0; i < 30 && result_valid !== 1'b1; i++) @(negedge clk_sys);
    if (result_valid !== 1'b1)
    begin
      failures++;
      test_done();
    end
    else
    begin
      chk(result, e);
    end
    @(posedge clk_sys);
  endtask
  task automatic run(int cnt);
    int ch;
    for (int i = 0; i < cnt; i++)
    begin
      ch = $urandom_range(0, 3);
      if (ch != 1 && $urandom_range(0, 9) == 0)
        base[ch] = int'($urandom_range(0, 200000)) - 100000;
      send(ch, base[ch] + int'($urandom_range(0, 2 * sp[ch])) - sp[ch]);
    end
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    srst = 1'b1;
    setup_valid = 1'b0;
    setup = '0;
    go = 1'b0;
    next_sample = '0;
    void'($urandom(32'hac0c));
    rst_seq();
    cfg(0, 1, 1);
    cfg(1, 255, 65535);
    cfg(2, 0, 0);
    cfg(3, 10, 1000);
    run(1200);
    rst_seq();
    run(150);
    test_done();
  end
endmodule
